// File: slr_config.sv
`timescale 1ns/1ps
`default_nettype none

// small first-word-fall-through buffer
module slr_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_q, rd_q;    // pointers
  logic [AW:0]      cnt_q;         // fill level
  logic             rdy_q;         // room flag, a flop so the port is clean
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire [AW:0]       cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop); // level after this edge

  assign in_ready  = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  // storage has no reset, only pointers, level and room flag do
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointer and level bookkeeping
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {wr_q, rd_q, cnt_q} <= '0;
      rdy_q <= 1'b1;       // empty buffer always has room
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule // slr_fifo

module slr_config import slr_pkg::*; #(
  parameter int FIFO_DEPTH   = 4,
  parameter int FREE_RUNNING_SEND_ENABLE_PER_US = 250  // free-running period, microseconds
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psi5_mode,
  input  wire logic              diag_mode,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_ack,
  output logic                   reg_refused,
  output logic                   array_error,
  input  wire logic              sync_pulse,
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire slr_sample_s       sample,
  output logic                   tx_valid,
  output logic [9:0]             tx_data,
  output logic [2:0]             tx_check,
  output logic                   tx_source,
  input  wire logic              brc_valid,
  input  wire logic              brc_type,
  output logic                   slot0_brc_answer,
  output logic                   slot1_brc_answer,
  output logic                   phase2_extra_fields_enable,
  output logic                   daisy_chain_mode,
  output logic                   free_running_active
);
  // register array
  logic [7:0] opt_q, s0l_q, s0h_q, s1l_q, s1h_q;
  logic [7:0] chk_q;                   // reference for array check
  logic [7:0] rdata_q;
  logic       ack_q, refused_q, arr_err_q;

  // access only in dsi3 or psi5 diagnostic mode
  wire access_ok = !psi5_mode || diag_mode;
  wire hit_opt = (reg_addr == OFS_OPTIONS);
  wire hit_s0l = (reg_addr == OFS_S0_LOW);
  wire hit_s0h = (reg_addr == OFS_S0_HIGH);
  wire hit_s1l = (reg_addr == OFS_S1_LOW);
  wire hit_s1h = (reg_addr == OFS_S1_HIGH);
  wire wr_ok   = reg_wr && access_ok;
  wire rd_ok   = reg_rd && access_ok;

  // read mux, unmapped addresses read as zero
  wire [7:0] rd_mux = hit_opt ? opt_q : hit_s0l ? s0l_q : hit_s0h ? s0h_q
                    : hit_s1l ? s1l_q : hit_s1h ? s1h_q : 8'h00;

  // xor fold over the writable array
  wire [7:0] fold_now = opt_q ^ s0l_q ^ s0h_q ^ s1l_q ^ s1h_q;

  // register writes; every bit stays r/w in either protocol
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {opt_q, s0l_q, s0h_q, s1l_q, s1h_q} <= {5{RESET_BYTE}};
    end else if (wr_ok) begin
      if (hit_opt) opt_q <= reg_wdata;
      if (hit_s0l) s0l_q <= reg_wdata;
      if (hit_s0h) s0h_q <= reg_wdata;
      if (hit_s1l) s1l_q <= reg_wdata;
      if (hit_s1h) s1h_q <= reg_wdata;
    end
  end

  // reference fold follows legal writes one cycle late
  logic wr_seen_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {wr_seen_q, arr_err_q} <= 2'b00;
      chk_q     <= RESET_BYTE;
    end else begin
      wr_seen_q <= wr_ok;
      if (wr_seen_q) begin
        chk_q <= fold_now;
      end else if (fold_now != chk_q) begin
        arr_err_q <= 1'b1; // sticky until reset; an upset is not healed
      end
    end
  end

  // bus answer one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {rdata_q, ack_q, refused_q} <= 10'h000;
    end else begin
      ack_q     <= wr_ok || rd_ok;
      refused_q <= (reg_wr || reg_rd) && !access_ok;
      if (rd_ok) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // decoded option bits, psi5 only
  wire wide_pressure_range_enable = opt_q[BIT_WIDE];
  wire error_detail_enable        = opt_q[BIT_EMSG];
  wire crc_select                 = psi5_mode && opt_q[BIT_CRC];
  wire daisy                      = psi5_mode && opt_q[BIT_DAISY];
  wire free_running_send_enable_on = psi5_mode && opt_q[BIT_FREE_RUNNING_SEND_ENABLE] && !opt_q[BIT_DAISY];

  // start time fields and effective start in microseconds
  wire [TIME_W-1:0] slot0_start_time = {s0h_q[HI_TIME_W-1:0], s0l_q};
  wire [TIME_W-1:0] slot1_start_time = {s1h_q[HI_TIME_W-1:0], s1l_q};
  wire [1:0] slot0_broadcast_select  = s0h_q[HI_SEL_LSB +: 2];
  wire [1:0] slot1_broadcast_select  = s1h_q[HI_SEL_LSB +: 2];

  // zero, small and exactly 20 all map to the 20 us floor
  function automatic logic [TIME_W-1:0] eff_start(input logic [TIME_W-1:0] v);
    eff_start = (v <= TIME_W'(MIN_START_US)) ? TIME_W'(MIN_START_US)
                                             : v;
  endfunction

  // broadcast answer decode, 00 and 11 answer all
  function automatic logic brc_match(input logic [1:0] sel, input logic typ);
    brc_match = (sel == 2'b00) || (sel == 2'b11) || (sel == {typ, !typ});
  endfunction

  wire [TIME_W-1:0] start0 = eff_start(slot0_start_time);
  wire [TIME_W-1:0] start1 = eff_start(slot1_start_time);

  // microsecond enable from the system clock
  localparam int DIV_W = $clog2(CYC_PER_US);
  logic [DIV_W-1:0] div_q;
  wire              us_tick = (div_q == DIV_W'(CYC_PER_US - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= (sync_pulse || us_tick) ? '0 : div_q + 1'b1;
    end
  end

  // microseconds since the timing reference, saturating
  logic [TIME_W-1:0] us_q;
  logic              live_q;       // a frame is being timed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {us_q, live_q} <= '0;
    end else if (sync_pulse) begin
      us_q   <= '0;
      live_q <= 1'b1;
    end else if (us_tick && live_q) begin
      if (us_q == '1) begin
        live_q <= 1'b0;
      end else begin
        us_q <= us_q + 1'b1;
      end
    end
  end

  // free-running period counter for free_running_send_enable sending
  localparam int APW = $clog2(FREE_RUNNING_SEND_ENABLE_PER_US + 1);
  logic [APW-1:0] ap_q;
  wire free_running_send_enable_fire = free_running_send_enable_on && us_tick && (ap_q == APW'(FREE_RUNNING_SEND_ENABLE_PER_US - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ap_q <= '0;
    end else if (!free_running_send_enable_on || free_running_send_enable_fire) begin
      ap_q <= '0;
    end else if (us_tick) begin
      ap_q <= ap_q + 1'b1;
    end
  end

  // slot fire pulses; free_running_send_enable mode takes over source 0, drops source 1
  wire sync_hit0 = live_q && us_tick && (us_q + 1'b1 == start0);
  wire sync_hit1 = live_q && us_tick && (us_q + 1'b1 == start1);
  wire fire0 = free_running_send_enable_on ? free_running_send_enable_fire : sync_hit0;
  wire fire1 = !free_running_send_enable_on && sync_hit1;

  // sample buffer; sender pops only at a slot so the buffer really fills
  slr_sample_s head;
  logic        head_valid;
  wire         pop = head_valid && (fire0 || fire1);
  slr_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // clip bounds by range bit
  wire signed [11:0] lo = wide_pressure_range_enable ? WIDE_MIN : NARROW_MIN;
  wire signed [11:0] hi = wide_pressure_range_enable ? WIDE_MAX : NARROW_MAX;
  wire signed [11:0] clipped = (head.value < lo) ? lo : (head.value > hi) ? hi : head.value;
  wire [9:0] err_code = error_detail_enable ? ERR_CODE_BASE + 10'(head.err_kind)
                                            : ERR_CODE_BASE;
  wire [9:0] clip10 = clipped[9:0];
  wire [9:0] psi5_word = head.err ? err_code : clip10;
  wire [9:0] word = psi5_mode ? psi5_word : head.value[9:0];

  // crc3 over ten bits, msb first, x^3+x+1
  function automatic logic [2:0] crc3(input logic [9:0] d);
    logic [2:0] c;
    logic       fb;
    c = CRC_SEED;
    for (int i = 9; i >= 0; i--) begin
      fb = c[2] ^ d[i];
      c  = {c[1], c[0] ^ fb, fb};
    end
    crc3 = c;
  endfunction

  wire [2:0] check = !psi5_mode ? 3'h0
                   : crc_select ? crc3(word)
                   : {2'b00, ^word};                   // even parity

  // transmit register
  logic       txv_q, txs_q;
  logic [9:0] txd_q;
  logic [2:0] txc_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {txv_q, txs_q, txd_q, txc_q} <= 15'h0000;
    end else begin
      txv_q <= pop;
      if (pop) begin
        txs_q <= !fire0; // source 0 wins a shared slot
        txd_q <= word;
        txc_q <= check;
      end
    end
  end

  // broadcast answers and mode flags
  logic b0_q, b1_q, p2_q, dc_q, fr_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {b0_q, b1_q, p2_q, dc_q, fr_q} <= 5'h00;
    end else begin
      b0_q <= brc_valid && brc_match(slot0_broadcast_select, brc_type);
      b1_q <= brc_valid && brc_match(slot1_broadcast_select, brc_type);
      p2_q <= psi5_mode && opt_q[BIT_INIT2];
      dc_q <= daisy;
      fr_q <= free_running_send_enable_on;
    end
  end

  assign reg_rdata                  = rdata_q;
  assign reg_ack                    = ack_q;
  assign reg_refused                = refused_q;
  assign array_error                = arr_err_q;
  assign tx_valid                   = txv_q;
  assign tx_data                    = txd_q;
  assign tx_check                   = txc_q;
  assign tx_source                  = txs_q;
  assign slot0_brc_answer           = b0_q;
  assign slot1_brc_answer           = b1_q;
  assign phase2_extra_fields_enable = p2_q;
  assign daisy_chain_mode           = dc_q;
  assign free_running_active        = fr_q;
endmodule // slr_config
`default_nettype wire

// File: slr_config_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for the response configuration block
module slr_config_checker import slr_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       psi5_mode,
  input wire logic       diag_mode,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_ack,
  input wire logic       reg_refused,
  input wire logic       sync_pulse,
  input wire logic       tx_valid,
  input wire logic [9:0] tx_data,
  input wire logic [2:0] tx_check,
  input wire logic       brc_valid,
  input wire logic       slot0_brc_answer,
  input wire logic       slot1_brc_answer,
  input wire logic       daisy_chain_mode,
  input wire logic       free_running_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // slack of two cycles for the phase of the microsecond tick
  localparam int MIN_GAP = MIN_START_US * CYC_PER_US - 2;
  int unsigned   since_q;  // cycles since the last timing reference
  // saturating, so a long idle gap never wraps back into range
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_q <= 0;
    end else if (sync_pulse) begin
      since_q <= 0;
    end else if (since_q < 32'd100000) begin
      since_q <= since_q + 1;
    end
  end
  sequence s_take; (reg_wr || reg_rd) && (!psi5_mode || diag_mode); endsequence
  sequence s_deny; (reg_wr || reg_rd) && psi5_mode && !diag_mode; endsequence
  property p_ack; s_take |=> reg_ack && !reg_refused; endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_deny; s_deny |=> reg_refused && !reg_ack; endproperty
  a_deny: assert property (p_deny) else $error("access not refused");
  property p_brc; slot0_brc_answer || slot1_brc_answer |-> $past(brc_valid); endproperty
  a_brc: assert property (p_brc) else $error("answer without broadcast");
  property p_range;
    tx_valid && psi5_mode |-> tx_data inside {[10'h1f4:10'h1f7]}
      || ($signed(tx_data) >= -10'sd480 && $signed(tx_data) <= 10'sd480);
  endproperty
  a_range: assert property (p_range) else $error("word out of range");
  property p_dsi3; tx_valid && !psi5_mode |-> tx_check == 3'h0; endproperty
  a_dsi3: assert property (p_dsi3) else $error("check bits in dsi3");
  property p_pulse; tx_valid |=> !tx_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("send longer than a cycle");
  property p_start; tx_valid && !free_running_active |-> since_q >= MIN_GAP; endproperty
  a_start: assert property (p_start) else $error("send before 20us");
  property p_free; free_running_active |-> !daisy_chain_mode && $past(psi5_mode); endproperty
  a_free: assert property (p_free) else $error("free run not allowed");
endmodule // slr_config_checker

bind slr_config slr_config_checker u_chk (
  .clk_sys, .rst, .psi5_mode, .diag_mode, .reg_wr, .reg_rd, .reg_ack, .reg_refused,
  .sync_pulse, .tx_valid, .tx_data, .tx_check, .brc_valid, .slot0_brc_answer,
  .slot1_brc_answer, .daisy_chain_mode, .free_running_active
);
`default_nettype wire

// File: slr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master on the far side: register strobes, sync and broadcast pulses
module slr_master_model (
  input  wire logic       clk_sys,
  input  wire logic       reg_ack,
  input  wire logic       reg_refused,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            sync_pulse,
  output logic            brc_valid,
  output logic            brc_type
);
  // idle bus at time zero
  initial begin
    {reg_wr, reg_rd, sync_pulse, brc_valid, brc_type} = 5'h00;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe; answer is sampled the cycle after it
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [1:0] st, output logic [7:0] q);
    @(posedge clk_sys);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;  // released lines scrambled, not held
    reg_wdata <= ~d;
    #1;
    st = {reg_refused, reg_ack};
    q  = reg_rdata;
  endtask
  // one-cycle timing reference or broadcast read
  task automatic pulse(input logic brc, input logic t);
    @(posedge clk_sys);
    sync_pulse <= !brc;
    brc_valid  <= brc;
    brc_type   <= t;
    @(posedge clk_sys);
    sync_pulse <= 1'b0;
    brc_valid  <= 1'b0;
    brc_type   <= ~t;
  endtask
endmodule // slr_master_model
`default_nettype wire

// File: slr_pkg.sv
`default_nettype none
package slr_pkg;
  // register offsets on the sensor bus register array
  localparam logic [7:0] OFS_OPTIONS  = 8'h25;
  localparam logic [7:0] OFS_S0_LOW   = 8'h26;
  localparam logic [7:0] OFS_S0_HIGH  = 8'h27;
  localparam logic [7:0] OFS_S1_LOW   = 8'h28;
  localparam logic [7:0] OFS_S1_HIGH  = 8'h29;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  // option bit positions
  localparam int BIT_FREE_RUNNING_SEND_ENABLE   = 0;
  localparam int BIT_INIT2   = 1;
  localparam int BIT_CRC     = 2;
  localparam int BIT_EMSG    = 3;
  localparam int BIT_WIDE    = 4;
  localparam int BIT_DAISY   = 6;
  // high start register layout
  localparam int HI_TIME_W   = 5;
  localparam int HI_SEL_LSB  = 6;
  localparam int TIME_W      = 13;
  // clipping limits in lsb
  localparam logic signed [11:0] NARROW_MIN = -12'sd102;
  localparam logic signed [11:0] NARROW_MAX = 12'sd307;
  localparam logic signed [11:0] WIDE_MIN   = -12'sd480;
  localparam logic signed [11:0] WIDE_MAX   = 12'sd480;
  // error codes
  localparam logic [9:0] ERR_CODE_BASE = 10'h1f4;
  // timing
  localparam int CLK_NS       = 50;
  localparam int US_NS        = 1000;
  localparam int CYC_PER_US   = US_NS / CLK_NS;
  localparam int MIN_START_US = 20;
  localparam logic [2:0] CRC_SEED = 3'h7;
  // sample carried through the buffer
  typedef struct packed {
    logic              err;
    logic [1:0]        err_kind;
    logic signed [11:0] value;
  } slr_sample_s;
  localparam int SAMPLE_W = $bits(slr_sample_s);
endpackage
`default_nettype wire

// File: tb_sensor_link_response_config.sv
`timescale 1ns/1ps
`default_nettype none
// register and sample-queue model compared with the block
module tb_sensor_link_response_config import slr_pkg::*; ();
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psi5_mode = 1'b0;
  logic        diag_mode = 1'b0;
  logic        sample_valid = 1'b0;
  slr_sample_s sample = '0;
  logic        reg_wr, reg_rd, sync_pulse, brc_valid, brc_type, reg_ack, reg_refused;
  logic        array_error, sample_ready, tx_valid, tx_source, daisy_chain_mode;
  logic        slot0_brc_answer, slot1_brc_answer, phase2_extra_fields_enable;
  logic        free_running_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
  logic [9:0]  tx_data;
  logic [2:0]  tx_check;
  logic [1:0]  st;
  logic [7:0]  regs [logic [7:0]];  // register model
  slr_sample_s sq [$];              // samples waiting for a slot
  int          bad_count = 0, compares = 0, seed = 30, n, u;
  int          starts [4] = '{0, 7, 20, 25};
  logic [7:0]  opts [4] = '{8'h00, 8'h10, 8'h08, 8'h1c};
  always #25 clk_sys = ~clk_sys;
  // short free-running period keeps the run brief
  slr_config #(.FIFO_DEPTH(4), .FREE_RUNNING_SEND_ENABLE_PER_US(3)) dut (
    .clk_sys, .rst, .psi5_mode, .diag_mode, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .reg_refused, .array_error, .sync_pulse, .sample_valid,
    .sample_ready, .sample, .tx_valid, .tx_data, .tx_check, .tx_source, .brc_valid,
    .brc_type, .slot0_brc_answer, .slot1_brc_answer, .phase2_extra_fields_enable,
    .daisy_chain_mode, .free_running_active);
  slr_master_model m (.clk_sys, .reg_ack, .reg_refused, .reg_rdata, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .sync_pulse, .brc_valid, .brc_type);
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // mode pins move on an edge, settled before use
  task automatic mode(input logic p, input logic d);
    @(posedge clk_sys);
    psi5_mode <= p;
    diag_mode <= d;
    #1;
  endtask
  // access through the master; model stores accepted writes to mapped places
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    ok = !psi5_mode || diag_mode;
    m.access(w, a, d, st, q);
    chk("status", 10'({!ok, ok}), 10'(st));
    if (ok && w && a inside {[8'h25:8'h29]}) regs[a] = d;
    if (ok && !w) chk("rdata", 10'(regs.exists(a) ? regs[a] : 8'h00), 10'(q));
  endtask
  // expected word: clip and error codes only in psi5
  function automatic logic [9:0] word(slr_sample_s s);
    int v;
    v = s.value;
    if (psi5_mode && s.err) return 10'h1f4 + (regs[8'h25][3] ? s.err_kind : 2'd0);
    if (psi5_mode && regs[8'h25][4]) v = v < -480 ? -480 : (v > 480 ? 480 : v);
    else if (psi5_mode) v = v < -102 ? -102 : (v > 307 ? 307 : v);
    return v[9:0];
  endfunction
  // bench crc3, msb first, x^3+x+1 from the package seed
  function automatic logic [2:0] crc(input logic [9:0] d);
    logic [2:0] c;
    c = CRC_SEED;
    for (int i = 9; i >= 0; i--) c = {c[1], c[0] ^ c[2] ^ d[i], c[2] ^ d[i]};
    return c;
  endfunction
  // only called while the buffer has room
  task automatic push(input logic e, input logic [1:0] k, input int v);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample       <= '{e, k, v[11:0]};
    sq.push_back(slr_sample_s'{e, k, v[11:0]});
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample       <= '{~e, ~k, ~v[11:0]};
  endtask
  // next sent word within [lo, hi] cycles, against the oldest sample
  task automatic rx(input logic src, input int lo, input int hi);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (!tx_valid && n < hi);
    chk("tx time", 10'(1), 10'(n >= lo && n <= hi));
    chk("tx source", 10'(src), 10'(tx_source));
    chk("tx data", word(sq.pop_front()), tx_data);
    if (psi5_mode && !regs[8'h25][2]) chk("parity", 10'(^tx_data), 10'(tx_check[0]));
    else if (psi5_mode) chk("crc", 10'(crc(tx_data)), 10'(tx_check));
  endtask
  task automatic slots(input int s0, input int s1);
    acc(1'b1, 8'h26, s0[7:0]);
    acc(1'b1, 8'h27, 8'(s0 >> 8));
    acc(1'b1, 8'h28, s1[7:0]);
    acc(1'b1, 8'h29, 8'(s1 >> 8));
  endtask
  initial begin
    for (int a = 8'h25; a <= 8'h29; a++) regs[8'(a)] = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, random write and read back, one unmapped place
    for (int a = 8'h25; a <= 8'h2a; a++) begin
      acc(1'b0, 8'(a), 8'h00);
      acc(1'b1, 8'(a), 8'(rnd()));
      acc(1'b0, 8'(a), 8'h00);
    end
    chk("array check", 10'(0), 10'(array_error));
    $display("test registers done");
    // psi5 without diagnostic refuses, diagnostic accepts
    mode(1'b1, 1'b0);
    acc(1'b1, 8'h26, 8'h5a);
    acc(1'b0, 8'h26, 8'h00);
    mode(1'b1, 1'b1);
    acc(1'b0, 8'h26, 8'h00);
    acc(1'b1, 8'h25, 8'h00);
    mode(1'b0, 1'b0);
    $display("test access modes done");
    // every selector code against both broadcast types
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 8'h27, 8'(s << 6));
      acc(1'b1, 8'h29, 8'((3 - s) << 6));
      for (int t = 0; t < 2; t++) begin
        m.pulse(1'b1, 1'(t));
        #1;
        chk("ans0", 10'(s == 0 || s == 3 || s == t + 1), 10'(slot0_brc_answer));
        chk("ans1", 10'(s == 0 || s == 3 || 3 - s == t + 1), 10'(slot1_brc_answer));
      end
    end
    $display("test broadcast done");
    // start time boundaries: zero, below 20, exactly 20, above 20
    foreach (starts[i]) begin
      slots(starts[i], 60);
      push(1'b0, 2'd0, rnd());
      push(1'b0, 2'd0, rnd());
      m.pulse(1'b0, 1'b0);
      u = starts[i] < 20 ? 20 : starts[i];
      rx(1'b0, u * 20 - 8, u * 20 + 8);
      rx(1'b1, (60 - u) * 20 - 8, (60 - u) * 20 + 8);
    end
    // fill until refused, drain over two frames
    repeat (4) push(1'b0, 2'd0, rnd());
    #1;
    chk("ready full", 10'(0), 10'(sample_ready));
    repeat (2) begin
      m.pulse(1'b0, 1'b0);
      rx(1'b0, 492, 508);
      rx(1'b1, 692, 708);
    end
    chk("ready empty", 10'(1), 10'(sample_ready));
    $display("test start times done");
    // psi5 clipping, error codes and parity or crc per option setting
    mode(1'b1, 1'b1);
    slots(0, 60);
    foreach (opts[i]) begin
      mode(1'b1, 1'b1);
      acc(1'b1, 8'h25, opts[i]);
      mode(1'b1, 1'b0);
      push(1'b0, 2'd0, (rnd() & 1) ? 600 : -600);
      push(1'b1, 2'(rnd()), 0);
      m.pulse(1'b0, 1'b0);
      rx(1'b0, 392, 408);
      rx(1'b1, 792, 808);
    end
    $display("test psi5 data done");
    // free running, then daisy chain blocks it, then dsi3 ignores the bits
    mode(1'b1, 1'b1);
    acc(1'b1, 8'h25, 8'h03);
    mode(1'b1, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("free run", 10'(1), 10'(free_running_active));
    chk("phase2", 10'(1), 10'(phase2_extra_fields_enable));
    push(1'b0, 2'd0, 100);
    rx(1'b0, 1, 80);
    mode(1'b1, 1'b1);
    acc(1'b1, 8'h25, 8'h43);
    repeat (2) @(posedge clk_sys);
    chk("daisy free run", 10'(0), 10'(free_running_active));
    chk("daisy", 10'(1), 10'(daisy_chain_mode));
    mode(1'b0, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("dsi3 phase2", 10'(0), 10'(phase2_extra_fields_enable));
    chk("array check", 10'(0), 10'(array_error));
    $display("test option levels done");
    results();
  end
  // hang guard: the tests need under 20000 cycles
  initial begin
    #(60000 * 50);
    bad_count++;
    results();
  end
endmodule // tb_sensor_link_response_config
`default_nettype wire
